// ### hdl/dcd_pkg.sv
package dcd_pkg;

	// ----------------------------------------------------------------
	// Bus widths
	// ----------------------------------------------------------------
	localparam int BANK_W = 3;
	localparam int ADDR_W = 14;

	// ----------------------------------------------------------------
	// Address field positions
	// ----------------------------------------------------------------
	localparam int AUTO_PRE_BIT = 10;
	localparam int CHOP_BIT = 12;
	localparam int COL_W = 10;

	// ----------------------------------------------------------------
	// Burst lengths in beats and divider setting
	// ----------------------------------------------------------------
	localparam logic [3:0] BEATS_FULL = 4'h8;
	localparam logic [3:0] BEATS_CHOP = 4'h4;
	localparam logic [3:0] LINK_DIV_HALF = 4'h4;

	// ----------------------------------------------------------------
	// Decoded commands
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		DCD_NOP      = 5'h00,
		DCD_DESELECT = 5'h01,
		DCD_MODE_SET = 5'h02,
		DCD_REFRESH  = 5'h03,
		DCD_SR_ENTRY = 5'h04,
		DCD_SR_EXIT  = 5'h05,
		DCD_PRE_ONE  = 5'h06,
		DCD_PRE_ALL  = 5'h07,
		DCD_ACTIVATE = 5'h08,
		DCD_WRITE    = 5'h09,
		DCD_READ     = 5'h0A,
		DCD_PD_ENTRY = 5'h0B,
		DCD_PD_EXIT  = 5'h0C,
		DCD_ZQ_LONG  = 5'h0D,
		DCD_ZQ_SHORT = 5'h0E,
		DCD_ILLEGAL  = 5'h1F
	} dcd_cmd_t;

endpackage

// ### hdl/dcd_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dcd_link_if;
	logic                            link_clk;
	logic                            cke;
	logic                            chip_sel_n;
	logic                            row_strobe_n;
	logic                            col_strobe_n;
	logic                            wr_en_n;
	logic                            term_ctl;
	logic [dcd_pkg::BANK_W-1:0]      bank;
	logic [dcd_pkg::ADDR_W-1:0]      addr;

	modport ctrl (
		output link_clk,
		output cke,
		output chip_sel_n,
		output row_strobe_n,
		output col_strobe_n,
		output wr_en_n,
		output term_ctl,
		output bank,
		output addr
	);

	modport mem (
		input link_clk,
		input cke,
		input chip_sel_n,
		input row_strobe_n,
		input col_strobe_n,
		input wr_en_n,
		input term_ctl,
		input bank,
		input addr
	);
endinterface
`default_nettype wire

// ### hdl/dcd_ctrl_end.sv
`timescale 1ns/100ps
`default_nettype none
module dcd_ctrl_end (
	input  wire logic                        ref_clk,
	input  wire logic                        rst_b,
	input  wire logic                        clk_en,
	input  wire logic                        cmd_valid,
	input  wire dcd_pkg::dcd_cmd_t           cmd,
	input  wire logic [dcd_pkg::BANK_W-1:0]  cmd_bank,
	input  wire logic [dcd_pkg::ADDR_W-1:0]  cmd_addr,
	input  wire logic                        cmd_term,
	output logic                             cmd_ready,
	dcd_link_if.ctrl                         link
);

	// ----------------------------------------------------------------
	// Link clock divider
	// ----------------------------------------------------------------
	logic [3:0] div_cnt;
	logic       link_clk;
	logic       fall_edge;

	assign fall_edge = clk_en && link_clk && (div_cnt == dcd_pkg::LINK_DIV_HALF - 4'h1);

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			div_cnt <= 4'h0;
			link_clk <= 1'b0;
		end
		else if (clk_en)
		begin
			if (div_cnt == dcd_pkg::LINK_DIV_HALF - 4'h1)
			begin
				div_cnt <= 4'h0;
				link_clk <= !link_clk;
			end
			else
				div_cnt <= div_cnt + 4'h1;
		end

	assign link.link_clk = link_clk;

	// ----------------------------------------------------------------
	// Command encoding, launched on the falling link edge
	// ----------------------------------------------------------------
	// Undriven fields stay at defined levels so the device never samples
	// floating inputs on a valid field.
	logic                       cke;
	logic [3:0]                 strobes;
	logic [dcd_pkg::BANK_W-1:0] bank;
	logic [dcd_pkg::ADDR_W-1:0] addr;
	logic                       term;

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			cke <= 1'b1;
			strobes <= 4'hF;
			bank <= '0;
			addr <= '0;
			term <= 1'b0;
		end
		else if (fall_edge)
		begin
			bank <= cmd_bank; // see R03
			addr <= cmd_addr; // see R04
			term <= cmd_term;
			strobes <= 4'hF;
			if (cmd_valid)
			begin
				unique case (cmd)
					dcd_pkg::DCD_MODE_SET: strobes <= 4'h0; // see R02
					dcd_pkg::DCD_REFRESH: strobes <= 4'h1; // see R19
					dcd_pkg::DCD_SR_ENTRY:
					begin
						strobes <= 4'h1; // see R19
						cke <= 1'b0;
					end
					dcd_pkg::DCD_PRE_ONE:
					begin
						strobes <= 4'h2; // see R20
						addr[dcd_pkg::AUTO_PRE_BIT] <= 1'b0;
					end
					dcd_pkg::DCD_PRE_ALL:
					begin
						strobes <= 4'h2; // see R20
						addr[dcd_pkg::AUTO_PRE_BIT] <= 1'b1;
					end
					dcd_pkg::DCD_ACTIVATE: strobes <= 4'h3; // see R20
					dcd_pkg::DCD_WRITE: strobes <= 4'h4; // see R05
					dcd_pkg::DCD_READ: strobes <= 4'h5; // see R09
					dcd_pkg::DCD_ZQ_LONG:
					begin
						strobes <= 4'h6; // see R21
						addr[dcd_pkg::AUTO_PRE_BIT] <= 1'b1;
					end
					dcd_pkg::DCD_ZQ_SHORT:
					begin
						strobes <= 4'h6; // see R21
						addr[dcd_pkg::AUTO_PRE_BIT] <= 1'b0;
					end
					dcd_pkg::DCD_PD_ENTRY: cke <= 1'b0; // see R22
					dcd_pkg::DCD_PD_EXIT, dcd_pkg::DCD_SR_EXIT:
						cke <= 1'b1; // see R22
					dcd_pkg::DCD_DESELECT: strobes <= 4'hF;
					default: strobes <= 4'h7;
				endcase
			end
		end

	// Strobe order is chip select, row, column, write enable.
	assign link.cke = cke;
	assign link.chip_sel_n = strobes[3];
	assign link.row_strobe_n = strobes[2];
	assign link.col_strobe_n = strobes[1];
	assign link.wr_en_n = strobes[0];
	assign link.term_ctl = term;
	assign link.bank = bank;
	assign link.addr = addr;

	// ----------------------------------------------------------------
	// Request handshake: one command per link cycle
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			cmd_ready <= 1'b0;
		else if (clk_en)
			cmd_ready <= fall_edge;

endmodule // dcd_ctrl_end
`default_nettype wire

// ### hdl/dcd_mem_end.sv
`timescale 1ns/100ps
`default_nettype none
// Operation
// R01 - Decode from strobes and clock enable
// R02 - All strobes low is mode register set
// R03 - Bank lines pick target bank
// R04 - Controller drives valid inputs defined
// R05 - Write: RAS high, CAS WE low
// R06 - On-the-fly write, A12 low: chop four
// R07 - On-the-fly write, A12 high: eight beats
// R08 - A10 high auto-precharges after burst
// R09 - Read: RAS high, CAS low, WE high
// R10 - On-the-fly read burst by A12
// R11 - Read auto precharge plus chosen length
// R12 - Bursts never cut short; mode picks
// R13 - NOP changes nothing, bursts continue
// R14 - Deselect behaves like NOP
// R15 - No internal refresh in power-down
// R16 - Termination ignored during self refresh
// R17 - Self refresh exit on clock enable
// R18 - Reset held high in normal operation
// R19 - Refresh pattern; falling enable self refresh
// R20 - Precharge and activate patterns, A10 all
// R21 - ZQ calibration by A10; power-down
// R22 - Only NOP or deselect at transitions
module dcd_mem_end (
	input  wire logic                        ref_clk,
	input  wire logic                        rst_b,
	input  wire logic                        clk_en,
	input  wire logic                        otf_enable,
	input  wire logic                        fixed_chop,
	dcd_link_if.mem                          link,
	output logic                             cmd_strobe,
	output dcd_pkg::dcd_cmd_t                cmd_code,
	output logic [dcd_pkg::BANK_W-1:0]       cmd_bank,
	output logic [dcd_pkg::ADDR_W-1:0]       cmd_addr,
	output logic                             cmd_auto_pre,
	output logic [3:0]                       cmd_beats,
	output logic                             burst_busy,
	output logic                             in_self_refresh,
	output logic                             in_power_down,
	output logic                             term_active
);

	// ----------------------------------------------------------------
	// Link domain: sample the command bus
	// ----------------------------------------------------------------
	logic                       cke_prev;
	logic                       self_ref;
	logic                       pwr_down;
	logic                       evt_tog;
	dcd_pkg::dcd_cmd_t          next_cmd;
	dcd_pkg::dcd_cmd_t          lk_cmd;
	logic [dcd_pkg::BANK_W-1:0] lk_bank;
	logic [dcd_pkg::ADDR_W-1:0] lk_addr;
	logic [3:0]                 lk_beats;
	logic [3:0]                 strobes;

	assign strobes = {link.chip_sel_n, link.row_strobe_n,
		link.col_strobe_n, link.wr_en_n};

	always_comb // see R01
	begin
		next_cmd = dcd_pkg::DCD_ILLEGAL;
		if (!cke_prev && link.cke)
			next_cmd = self_ref ? dcd_pkg::DCD_SR_EXIT // see R17
				: dcd_pkg::DCD_PD_EXIT; // see R21
		else if (!cke_prev)
			next_cmd = dcd_pkg::DCD_NOP; // see R15
		else if (strobes[3])
			next_cmd = link.cke ? dcd_pkg::DCD_DESELECT // see R14
				: dcd_pkg::DCD_PD_ENTRY;
		// Clock enable may only fall with a deselect (taken above), a refresh or a NOP pattern.
		else if (!link.cke && strobes[2:0] != 3'h1
			&& strobes[2:0] != 3'h7)
			next_cmd = dcd_pkg::DCD_ILLEGAL; // see R21
		else
		begin
			unique case (strobes[2:0])
				3'h0: next_cmd = dcd_pkg::DCD_MODE_SET; // see R02
				3'h1: next_cmd = link.cke ? dcd_pkg::DCD_REFRESH
					: dcd_pkg::DCD_SR_ENTRY; // see R19
				3'h2: next_cmd = link.addr[dcd_pkg::AUTO_PRE_BIT]
					? dcd_pkg::DCD_PRE_ALL : dcd_pkg::DCD_PRE_ONE; // see R20
				3'h3: next_cmd = dcd_pkg::DCD_ACTIVATE; // see R20
				3'h4: next_cmd = dcd_pkg::DCD_WRITE; // see R05
				3'h5: next_cmd = dcd_pkg::DCD_READ; // see R09
				3'h6: next_cmd = link.addr[dcd_pkg::AUTO_PRE_BIT]
					? dcd_pkg::DCD_ZQ_LONG : dcd_pkg::DCD_ZQ_SHORT; // see R21
				3'h7: next_cmd = link.cke ? dcd_pkg::DCD_NOP // see R13
					: dcd_pkg::DCD_PD_ENTRY;
			endcase
		end
	end

	always_ff @(posedge link.link_clk or negedge rst_b)
		if (!rst_b)
		begin
			cke_prev <= 1'b1;
			self_ref <= 1'b0;
			pwr_down <= 1'b0;
			evt_tog <= 1'b0;
			lk_cmd <= dcd_pkg::DCD_NOP;
			lk_bank <= '0;
			lk_addr <= '0;
			lk_beats <= 4'h0;
		end
		else
		begin
			cke_prev <= link.cke;
			if (next_cmd == dcd_pkg::DCD_SR_ENTRY)
				self_ref <= 1'b1;
			else if (next_cmd == dcd_pkg::DCD_SR_EXIT)
				self_ref <= 1'b0;
			if (next_cmd == dcd_pkg::DCD_PD_ENTRY)
				pwr_down <= 1'b1;
			else if (next_cmd == dcd_pkg::DCD_PD_EXIT)
				pwr_down <= 1'b0;
			// NOP and deselect register nothing new.
			if (next_cmd != dcd_pkg::DCD_NOP
				&& next_cmd != dcd_pkg::DCD_DESELECT) // see R13
			begin
				evt_tog <= !evt_tog;
				lk_cmd <= next_cmd;
				lk_bank <= link.bank; // see R03
				lk_addr <= link.addr;
				if (otf_enable) // see R06, R07, R10
					lk_beats <= link.addr[dcd_pkg::CHOP_BIT]
						? dcd_pkg::BEATS_FULL : dcd_pkg::BEATS_CHOP;
				else // see R12
					lk_beats <= fixed_chop ? dcd_pkg::BEATS_CHOP
						: dcd_pkg::BEATS_FULL;
			end
		end

	// ----------------------------------------------------------------
	// Crossing into the reference domain
	// ----------------------------------------------------------------
	// The payload is held stable from one toggle to the next, and the
	// controller spaces commands by a full link cycle, so it is safe to
	// take it once the synchronised toggle has changed.
	logic [2:0] tog_sync;
	logic       sr_s1;
	logic       sr_s2;
	logic       pd_s1;
	logic       pd_s2;
	logic       term_s1;
	logic       term_s2;

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			tog_sync <= 3'h0;
			{sr_s1, sr_s2, pd_s1, pd_s2, term_s1, term_s2} <= 6'h00;
		end
		else if (clk_en)
		begin
			tog_sync <= {tog_sync[1:0], evt_tog};
			{sr_s1, sr_s2} <= {self_ref, sr_s1};
			{pd_s1, pd_s2} <= {pwr_down, pd_s1};
			{term_s1, term_s2} <= {link.term_ctl, term_s1};
		end

	// ----------------------------------------------------------------
	// Command outputs and burst tracking
	// ----------------------------------------------------------------
	logic       new_evt;
	logic [3:0] beat_cnt;
	logic       is_burst;

	assign new_evt = tog_sync[2] != tog_sync[1];
	assign is_burst = lk_cmd == dcd_pkg::DCD_READ
		|| lk_cmd == dcd_pkg::DCD_WRITE;

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			cmd_strobe <= 1'b0;
			cmd_code <= dcd_pkg::DCD_NOP;
			cmd_bank <= '0;
			cmd_addr <= '0;
			cmd_auto_pre <= 1'b0;
			cmd_beats <= 4'h0;
		end
		else if (clk_en)
		begin
			cmd_strobe <= new_evt;
			if (new_evt)
			begin
				cmd_code <= lk_cmd;
				cmd_bank <= lk_bank; // see R03
				cmd_addr <= lk_addr;
				cmd_auto_pre <= is_burst
					&& lk_addr[dcd_pkg::AUTO_PRE_BIT]; // see R08, R11
				cmd_beats <= is_burst ? lk_beats : 4'h0;
			end
		end

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			beat_cnt <= 4'h0;
			burst_busy <= 1'b0;
		end
		else if (clk_en)
		begin
			// A burst only counts down; no command shortens it.
			// A back-to-back burst lands on the last beat of the one
			// before, so it must still load there.
			if (new_evt && is_burst && beat_cnt <= 4'h1)
				beat_cnt <= lk_beats;
			else if (beat_cnt != 4'h0)
				beat_cnt <= beat_cnt - 4'h1; // see R12
			burst_busy <= (new_evt && is_burst) || beat_cnt > 4'h1;
		end

	always_ff @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
		begin
			in_self_refresh <= 1'b0;
			in_power_down <= 1'b0;
			term_active <= 1'b0;
		end
		else if (clk_en)
		begin
			in_self_refresh <= sr_s2;
			in_power_down <= pd_s2; // see R15
			term_active <= term_s2 && !sr_s2; // see R16
		end

endmodule // dcd_mem_end
`default_nettype wire

// ### test/dcd_link_sva.sv
`timescale 1ns/100ps
`default_nettype none
module dcd_link_sva (
	input	wire logic				ref_clk,
	input	wire logic				rst_b,
	input	wire logic				link_clk,
	input	wire logic				cke,
	input	wire logic				chip_sel_n,
	input	wire logic				row_strobe_n,
	input	wire logic				col_strobe_n,
	input	wire logic				wr_en_n,
	input	wire logic				term_ctl,
	input	wire logic [dcd_pkg::BANK_W-1:0]	bank,
	input	wire logic [dcd_pkg::ADDR_W-1:0]	addr
);
	// ----------------------------------------------------------------
	// Link framing as seen from the fast clock
	// ----------------------------------------------------------------
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	wire	logic	quiet;
	wire	logic	refresh_pat;

	// Power state changes are only safe on a NOP or deselect pattern.
	assign quiet = chip_sel_n | (row_strobe_n & col_strobe_n & wr_en_n);
	// Self refresh is entered with a refresh pattern instead.
	assign refresh_pat = !chip_sel_n & !row_strobe_n & !col_strobe_n
		& wr_en_n;

	sequence s_launch;
		$fell(link_clk);
	endsequence
	sequence s_high_phase;
		link_clk [*4] ##1 !link_clk;
	endsequence
	sequence s_low_phase;
		!link_clk [*4] ##1 link_clk;
	endsequence

	property p_reset_idle;
		$rose(rst_b) |-> cke && chip_sel_n && !link_clk;
	endproperty
	property p_high;
		$rose(link_clk) |-> s_high_phase;
	endproperty
	property p_low;
		$fell(link_clk) |-> s_low_phase;
	endproperty
	property p_cmd_launch;
		$changed({chip_sel_n, row_strobe_n, col_strobe_n, wr_en_n})
			|-> s_launch;
	endproperty
	property p_addr_hold;
		link_clk |-> $stable(addr) && $stable(bank);
	endproperty
	property p_cke_launch;
		$changed(cke) |-> s_launch;
	endproperty
	property p_term_launch;
		$changed(term_ctl) |-> s_launch;
	endproperty
	property p_cke_fall;
		$fell(cke) |-> quiet || refresh_pat;
	endproperty
	property p_cke_rise;
		$rose(cke) |-> quiet;
	endproperty

	a_reset_idle: assert property (p_reset_idle)
		else $error("link not idle after reset");
	a_high: assert property (p_high)
		else $error("link clock high phase wrong");
	a_low: assert property (p_low)
		else $error("link clock low phase wrong");
	a_cmd_launch: assert property (p_cmd_launch)
		else $error("command lines moved off the falling link edge");
	a_addr_hold: assert property (p_addr_hold)
		else $error("bank or address moved while link clock high");
	a_cke_launch: assert property (p_cke_launch)
		else $error("clock enable moved off the falling link edge");
	a_term_launch: assert property (p_term_launch)
		else $error("termination moved off the falling link edge");
	a_cke_fall: assert property (p_cke_fall)
		else $error("clock enable fell with a real command");
	a_cke_rise: assert property (p_cke_rise)
		else $error("clock enable rose with a real command");
endmodule // dcd_link_sva
`default_nettype wire

// ### test/ddr3_command_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ddr3_command_decoder_tb;
	// ----------------------------------------------------------------
	// Stimulus, both ends and the fault link
	// ----------------------------------------------------------------
	logic				ref_clk = 1'b0;
	logic				rst_b = 1'b0;
	logic				clk_en = 1'b1;
	logic				cmd_valid = 1'b0;
	logic				cmd_term = 1'b0;
	logic				otf = 1'b1;
	logic				chop = 1'b0;
	dcd_pkg::dcd_cmd_t		cmd = dcd_pkg::DCD_NOP;
	logic [dcd_pkg::BANK_W-1:0]	cmd_bank = 3'h0;
	logic [dcd_pkg::ADDR_W-1:0]	cmd_addr = 14'h0000;
	logic				cmd_ready;
	logic				strobe;
	logic				strobe2;
	logic				auto_pre;
	logic				busy;
	logic				in_sr;
	logic				in_pd;
	logic				term_act;
	logic [3:0]			beats;
	dcd_pkg::dcd_cmd_t		code;
	dcd_pkg::dcd_cmd_t		code2;
	logic [dcd_pkg::BANK_W-1:0]	o_bank;
	logic [dcd_pkg::ADDR_W-1:0]	o_addr;
	int				n_errors = 0;
	int				checked = 0;

	dcd_link_if u_dcd_link_if ();
	dcd_link_if u_fault_link ();

	dcd_ctrl_end u_dcd_ctrl_end (
		.ref_clk	(ref_clk),
		.rst_b		(rst_b),
		.clk_en		(clk_en),
		.cmd_valid	(cmd_valid),
		.cmd		(cmd),
		.cmd_bank	(cmd_bank),
		.cmd_addr	(cmd_addr),
		.cmd_term	(cmd_term),
		.cmd_ready	(cmd_ready),
		.link		(u_dcd_link_if.ctrl)
	);
	dcd_mem_end u_dcd_mem_end (
		.ref_clk	(ref_clk),
		.rst_b		(rst_b),
		.clk_en		(clk_en),
		.otf_enable	(otf),
		.fixed_chop	(chop),
		.link		(u_dcd_link_if.mem),
		.cmd_strobe	(strobe),
		.cmd_code	(code),
		.cmd_bank	(o_bank),
		.cmd_addr	(o_addr),
		.cmd_auto_pre	(auto_pre),
		.cmd_beats	(beats),
		.burst_busy	(busy),
		.in_self_refresh	(in_sr),
		.in_power_down	(in_pd),
		.term_active	(term_act)
	);
	dcd_mem_end u_dcd_mem_end_fault (
		.ref_clk	(ref_clk),
		.rst_b		(rst_b),
		.clk_en		(clk_en),
		.otf_enable	(otf),
		.fixed_chop	(chop),
		.link		(u_fault_link.mem),
		.cmd_strobe	(strobe2),
		.cmd_code	(code2),
		.cmd_bank	(),
		.cmd_addr	(),
		.cmd_auto_pre	(),
		.cmd_beats	(),
		.burst_busy	(),
		.in_self_refresh	(),
		.in_power_down	(),
		.term_active	()
	);
	dcd_link_sva u_dcd_link_sva (
		.ref_clk	(ref_clk),
		.rst_b		(rst_b),
		.link_clk	(u_dcd_link_if.link_clk),
		.cke		(u_dcd_link_if.cke),
		.chip_sel_n	(u_dcd_link_if.chip_sel_n),
		.row_strobe_n	(u_dcd_link_if.row_strobe_n),
		.col_strobe_n	(u_dcd_link_if.col_strobe_n),
		.wr_en_n	(u_dcd_link_if.wr_en_n),
		.term_ctl	(u_dcd_link_if.term_ctl),
		.bank		(u_dcd_link_if.bank),
		.addr		(u_dcd_link_if.addr)
	);

	initial
		forever #5 ref_clk = ~ref_clk;

	// The fault link clock runs free, out of phase with the fast clock.
	initial
	begin
		u_fault_link.link_clk = 1'b0;
		{u_fault_link.cke, u_fault_link.chip_sel_n, u_fault_link.row_strobe_n,
			u_fault_link.col_strobe_n, u_fault_link.wr_en_n} = 5'h1F;
		u_fault_link.term_ctl = 1'b0;
		u_fault_link.bank = 3'h0;
		u_fault_link.addr = 14'h0000;
		#13;
		forever #40 u_fault_link.link_clk = ~u_fault_link.link_clk;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic test_done;
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic cyc;
		@(posedge ref_clk);
		#1;
	endtask

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_val(input string what, ref logic sig, input logic v);
		for (int i = 0; i < 40 && sig !== v; i++)
			cyc();
		chk(what, 16'(v), 16'(sig));
		if (sig !== v)
			test_done();
	endtask

	// The request is held until the edge that samples the ready pulse.
	task automatic send(input dcd_pkg::dcd_cmd_t c, input logic [13:0] a);
		cmd = c;
		cmd_addr = a;
		cmd_valid = 1'b1;
		wait_val("cmd_ready", cmd_ready, 1'b1);
		cyc();
		cmd_valid = 1'b0;
	endtask

	task automatic drv2(input logic [4:0] v);
		@(negedge u_fault_link.link_clk);
		{u_fault_link.cke, u_fault_link.chip_sel_n, u_fault_link.row_strobe_n,
			u_fault_link.col_strobe_n, u_fault_link.wr_en_n} = v;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_rw;
		logic [3:0] k;
		for (int i = 0; i < 16; i++)
		begin
			k = 4'(i);
			otf = !k[3];
			chop = k[2];
			cmd_bank = k[2:0] ^ 3'h5;
			send(k[0] ? dcd_pkg::DCD_READ : dcd_pkg::DCD_WRITE,
				{1'b0, k[2] ^ k[3], 1'b0, k[1], 6'h2A, k});
			wait_val("cmd_strobe", strobe, 1'b1);
			chk("code", 16'(k[0] ? dcd_pkg::DCD_READ : dcd_pkg::DCD_WRITE),
				16'(code));
			chk("bank", 16'(k[2:0] ^ 3'h5), 16'(o_bank));
			chk("addr", 16'(cmd_addr), 16'(o_addr));
			chk("auto_pre", 16'(k[1]), 16'(auto_pre));
			chk("beats", 16'((otf == k[2]) ? dcd_pkg::BEATS_FULL :
				dcd_pkg::BEATS_CHOP), 16'(beats));
			wait_val("burst_busy", busy, 1'b1);
		end
	endtask

	task automatic t_misc;
		dcd_pkg::dcd_cmd_t ops [7] = '{dcd_pkg::DCD_MODE_SET,
			dcd_pkg::DCD_ACTIVATE, dcd_pkg::DCD_PRE_ONE, dcd_pkg::DCD_PRE_ALL,
			dcd_pkg::DCD_REFRESH, dcd_pkg::DCD_ZQ_LONG, dcd_pkg::DCD_ZQ_SHORT};
		logic a10;
		for (int i = 0; i < 7; i++)
		begin
			a10 = ops[i] == dcd_pkg::DCD_PRE_ALL || ops[i] == dcd_pkg::DCD_ZQ_LONG;
			cmd_bank = 3'(i + 1);
			send(ops[i], {3'h0, a10, 10'h155});
			wait_val("cmd_strobe", strobe, 1'b1);
			chk("code", 16'(ops[i]), 16'(code));
			chk("auto_pre", 16'h0000, 16'(auto_pre));
			if (i < 3)
				chk("bank", 16'(i + 1), 16'(o_bank));
		end
	endtask

	task automatic t_quiet(input dcd_pkg::dcd_cmd_t c);
		send(c, 14'h3FFF);
		for (int i = 0; i < 16; i++)
		begin
			chk("no strobe", 16'h0000, 16'(strobe));
			cyc();
		end
		chk("burst_busy", 16'h0000, 16'(busy));
	endtask

	task automatic t_power;
		send(dcd_pkg::DCD_PD_ENTRY, 14'h0000);
		wait_val("in_power_down", in_pd, 1'b1);
		chk("in_self_refresh", 16'h0000, 16'(in_sr));
		send(dcd_pkg::DCD_PD_EXIT, 14'h0000);
		wait_val("in_power_down", in_pd, 1'b0);
		cmd_term = 1'b1;
		send(dcd_pkg::DCD_NOP, 14'h0000);
		wait_val("term_active", term_act, 1'b1);
		send(dcd_pkg::DCD_SR_ENTRY, 14'h0000);
		wait_val("in_self_refresh", in_sr, 1'b1);
		wait_val("term_active", term_act, 1'b0);
		send(dcd_pkg::DCD_SR_EXIT, 14'h0000);
		wait_val("in_self_refresh", in_sr, 1'b0);
		cmd_term = 1'b0;
	endtask

	// Clock enable drops together with a read, which is never legal.
	task automatic t_fault;
		drv2(5'h05);
		wait_val("strobe2", strobe2, 1'b1);
		chk("code2", 16'(dcd_pkg::DCD_ILLEGAL), 16'(code2));
		drv2(5'h17);
	endtask

	initial
	begin
		repeat (2) cyc();
		rst_b = 1'b1;
		repeat (2) cyc();
		chk("idle", 16'h0000, 16'({strobe, busy, in_sr, in_pd, term_act,
			auto_pre, 5'(code)}));
		t_rw();
		t_misc();
		t_quiet(dcd_pkg::DCD_NOP);
		t_quiet(dcd_pkg::DCD_DESELECT);
		t_power();
		t_fault();
		test_done();
	end
endmodule // ddr3_command_decoder_tb
`default_nettype wire
